//--- rtl/spi_sdr_params.svh
// constants for the serial port status, data and rate block
`ifndef SPI_SDR_PARAMS_SVH
`define SPI_SDR_PARAMS_SVH

`define SPI_OFF_DATA      8'h40
`define SPI_OFF_CTRL      8'h42
`define SPI_OFF_STAT      8'h43

`define SPI_STAT_DONE     7
`define SPI_STAT_WRITE_COLLISION_FLAG     6
`define SPI_STAT_FAULT    4

`define SPI_CTRL_IRQEN    7
`define SPI_CTRL_OUTEN    6
`define SPI_CTRL_MASTER_SELECT     4
`define SPI_CTRL_CPOL     3
`define SPI_CTRL_CPHA     2
`define SPI_CTRL_RATE_HI  1
`define SPI_CTRL_RATE_LO  0

`define SPI_CTRL_RST      1'b0
`define SPI_FLAG_RST      1'b0
`define SPI_RDATA_RST     8'h00

// half serial clock periods in processor clocks
`define SPI_HALF_DIV2     6'h01
`define SPI_HALF_DIV4     6'h02
`define SPI_HALF_DIV16    6'h08
`define SPI_HALF_DIV32    6'h10

`define SPI_LAST_EDGE     4'hf

`endif

//--- rtl/spi_sdr_pkg.sv
// types shared by the serial port status, data and rate block
package spi_sdr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } xfer_state_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } pad_s;

  typedef logic [7:0] byte_t;

endpackage

//--- rtl/spi_rate_div.sv
// serial clock half period tick generator for master mode
`include "spi_sdr_params.svh"

module spi_rate_div #(
  parameter int CNT_W = 6
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] rate_i,
  input  wire logic       div2_i,
  output logic            tick_o
);

  if (CNT_W < 6) begin : g_chk
    $error("spi_rate_div: CNT_W must be at least 6");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lim;

  function automatic logic [CNT_W-1:0] half_len(input logic [1:0] rate, input logic div2);
    logic [5:0] h;
    h = `SPI_HALF_DIV2;
    case (rate)
      2'h0:    h = `SPI_HALF_DIV2;
      2'h1:    h = `SPI_HALF_DIV4;
      2'h2:    h = `SPI_HALF_DIV16;
      default: h = `SPI_HALF_DIV32;
    endcase
    // optional halving comes ahead of the rate divider
    if (div2) begin
      h = {h[4:0], 1'b0};
    end
    return CNT_W'(h);
  endfunction

  assign lim = half_len(rate_i, div2_i) - CNT_W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= '0;
    end else if (cnt_q >= lim) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && (cnt_q >= lim);
    end
  end

endmodule // spi_rate_div

//--- rtl/spi_status_data_rate.sv
// serial port: rate select, transfer engine, status flags and data register
`include "spi_sdr_params.svh"

module spi_status_data_rate #(
  parameter bit DIV2_OPT = 1'b0,
  parameter int ADDR_W   = 8
) (
  input  wire logic                MCLK_I,
  input  wire logic                RST_I,
  input  wire logic [ADDR_W-1:0]   ADDR_I,
  input  wire logic [7:0]          WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  input  wire logic                SS_N_I,
  input  wire spi_sdr_pkg::pad_s   PAD_I,
  output logic [7:0]               RDATA_O,
  output logic                     IRQ_O,
  output spi_sdr_pkg::pad_s        PAD_O,
  output spi_sdr_pkg::pad_s        PAD_OE_N_O
);
  import spi_sdr_pkg::*;

  if (ADDR_W < 7) begin : g_chk
    $error("spi_status_data_rate: ADDR_W must be at least 7");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // control register
  logic        irq_en_q;
  logic        out_en_q;
  logic        master_select_q;
  logic        cpol_q;
  logic        cpha_q;
  logic [1:0]  rate_q;

  // status flags and their clear-sequence arms
  logic        done_q;
  logic        done_arm_q;
  logic        write_collision_flag_q;
  logic        write_collision_flag_arm_q;
  logic        fault_q;
  logic        fault_arm_q;

  // transfer engine
  xfer_state_e state_q;
  byte_t       shift_q;
  byte_t       rx_buf_q;
  logic [3:0]  edge_q;
  logic        latch_q;
  logic        sck_q;
  logic        sck_prev_q;
  logic        tick;
  logic        samp_q;
  logic        samp_now;
  byte_t       rx_next;

  pad_s        pad_q;
  pad_s        pad_oe_n_q;

  logic        wr_data;
  logic        rd_data;
  logic        wr_ctrl;
  logic        rd_stat;
  logic        master_en;
  logic        slave_en;
  logic        busy;
  logic        load_ok;
  logic        start;
  logic        m_edge;
  logic        s_edge;
  logic        sck_edge;
  logic        lead;
  logic        sample;
  logic        shift_e;
  logic        last;
  logic        serial_in;
  logic        shift_bit;
  logic        xfer_done;
  logic        done_clr;
  logic        write_collision_flag_set;
  logic        write_collision_flag_clr;
  logic        fault_set;
  logic        fault_clr;
  logic        ctrl_allow;

  assign wr_data = WR_I && hit(ADDR_I, `SPI_OFF_DATA);
  assign rd_data = RD_I && hit(ADDR_I, `SPI_OFF_DATA);
  assign wr_ctrl = WR_I && hit(ADDR_I, `SPI_OFF_CTRL);
  assign rd_stat = RD_I && hit(ADDR_I, `SPI_OFF_STAT);

  assign master_en = out_en_q && master_select_q;
  // rate field is not looked at here: slave timing is the far clock only
  assign slave_en  = out_en_q && !master_select_q && !SS_N_I;

  assign busy = (state_q == ST_SHIFT);

  // ---------------------------------------------------------------- flags

  // a master holds data writes off while an unacknowledged byte is pending
  assign load_ok = wr_data && !busy && !(master_select_q && done_q && !done_arm_q);
  assign start   = load_ok && master_en;

  assign xfer_done = (state_q == ST_DONE);
  // slave software may clear during the next byte; nothing blocks that
  assign done_clr  = done_arm_q && (rd_data || wr_data);

  assign write_collision_flag_set  = wr_data && busy;
  assign write_collision_flag_clr  = write_collision_flag_arm_q && (rd_data || (wr_data && done_q));

  // a select held low through the clear sequence re-raises the fault
  assign fault_set = master_select_q && !SS_N_I;
  assign fault_clr = fault_arm_q && wr_ctrl;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      done_q     <= `SPI_FLAG_RST;
      done_arm_q <= 1'b0;
    end else begin
      // a completing byte wins over a clear in the same cycle
      done_q     <= xfer_done || (done_q && !done_clr);
      if (done_clr || !done_q) begin
        done_arm_q <= 1'b0;
      end else if (rd_stat) begin
        done_arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      write_collision_flag_q     <= `SPI_FLAG_RST;
      write_collision_flag_arm_q <= 1'b0;
    end else begin
      write_collision_flag_q <= write_collision_flag_set || (write_collision_flag_q && !write_collision_flag_clr);
      if (write_collision_flag_clr || !write_collision_flag_q) begin
        write_collision_flag_arm_q <= 1'b0;
      end else if (rd_stat) begin
        write_collision_flag_arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      fault_q     <= `SPI_FLAG_RST;
      fault_arm_q <= 1'b0;
    end else begin
      fault_q <= fault_set || (fault_q && !fault_clr);
      if (fault_clr || !fault_q) begin
        fault_arm_q <= 1'b0;
      end else if (rd_stat) begin
        fault_arm_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------- control

  assign ctrl_allow = !fault_q || fault_arm_q;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      irq_en_q <= `SPI_CTRL_RST;
      out_en_q <= `SPI_CTRL_RST;
      master_select_q   <= `SPI_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        irq_en_q <= WDATA_I[`SPI_CTRL_IRQEN];
      end
      if (fault_set) begin
        out_en_q <= 1'b0;
        master_select_q   <= 1'b0;
      end else if (wr_ctrl) begin
        out_en_q <= WDATA_I[`SPI_CTRL_OUTEN] && ctrl_allow;
        master_select_q   <= WDATA_I[`SPI_CTRL_MASTER_SELECT] && ctrl_allow;
      end
    end
  end

  // timing and rate bits survive reset by design
  always_ff @(posedge MCLK_I) begin
    if (wr_ctrl) begin
      cpol_q <= WDATA_I[`SPI_CTRL_CPOL];
      cpha_q <= WDATA_I[`SPI_CTRL_CPHA];
      rate_q <= {WDATA_I[`SPI_CTRL_RATE_HI], WDATA_I[`SPI_CTRL_RATE_LO]};
    end
  end

  // ------------------------------------------------------------- engine

  spi_rate_div #(
    .CNT_W (6)
  ) u_rate (
    .clk_i  (MCLK_I),
    .rst_i  (RST_I),
    .run_i  (master_en && busy),
    .rate_i (rate_q),
    .div2_i (DIV2_OPT),
    .tick_o (tick)
  );

  assign m_edge   = master_en && busy && tick;
  // every processor clock looks at the far clock, so rates up to half of it work
  assign s_edge   = slave_en && (PAD_I.sck != sck_prev_q);
  assign sck_edge = m_edge || s_edge;
  assign lead     = master_select_q ? (sck_q == cpol_q) : (sck_prev_q == cpol_q);
  assign sample   = sck_edge && (lead != cpha_q);
  // with late phase the first leading edge only puts the msb out
  assign shift_e  = sck_edge && (lead == cpha_q) && !(cpha_q && edge_q == 4'h0);
  assign last     = sck_edge && (edge_q == `SPI_LAST_EDGE);
  assign serial_in = master_select_q ? PAD_I.miso : PAD_I.mosi;
  // master pins lag the internal clock by a cycle, so its sampling lags too
  assign samp_now  = master_select_q ? samp_q : sample;
  assign shift_bit = samp_now ? serial_in : latch_q;
  assign rx_next   = (master_select_q && cpha_q) ? {shift_q[6:0], shift_bit} : shift_q;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start || (slave_en && (!cpha_q || s_edge))) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (last) begin
            state_q <= ST_DONE;
          end else if (!master_en && !slave_en) begin
            // fault or deselect cuts the byte short, no completion
            state_q <= ST_IDLE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I || (state_q != ST_SHIFT && !(state_q == ST_IDLE && slave_en))) begin
      edge_q <= 4'h0;
    end else if (sck_edge) begin
      edge_q <= edge_q + 4'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      latch_q <= 1'b0;
    end else if (samp_now) begin
      latch_q <= serial_in;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      samp_q <= 1'b0;
    end else begin
      samp_q <= sample && master_select_q;
    end
  end

  // shifter has no reset: its content is undefined until written
  always_ff @(posedge MCLK_I) begin
    if (load_ok) begin
      shift_q <= WDATA_I;
    end else if (shift_e || (last && cpha_q && !master_select_q) || (xfer_done && cpha_q && master_select_q)) begin
      shift_q <= {shift_q[6:0], shift_bit};
    end
  end

  // buffer refills only when the previous byte was acknowledged
  always_ff @(posedge MCLK_I) begin
    if (xfer_done && (!done_q || done_clr)) begin
      rx_buf_q <= rx_next;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sck_q <= 1'b0;
    end else if (m_edge) begin
      sck_q <= !sck_q;
    end else if (!busy || !master_en) begin
      sck_q <= cpol_q;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= PAD_I.sck;
    end
  end

  // ------------------------------------------------------------- outputs

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pad_q      <= '0;
      pad_oe_n_q <= '1;
    end else begin
      pad_q.sck       <= sck_q;
      pad_q.mosi      <= shift_q[7];
      pad_q.miso      <= shift_q[7];
      // fault drops enable and master on this same edge, so these enables release a cycle later
      pad_oe_n_q.sck  <= !master_en;
      pad_oe_n_q.mosi <= !master_en;
      pad_oe_n_q.miso <= !slave_en;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= irq_en_q && (done_q || fault_q);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= `SPI_RDATA_RST;
    end else if (!RD_I) begin
      RDATA_O <= `SPI_RDATA_RST;
    end else if (hit(ADDR_I, `SPI_OFF_DATA)) begin
      RDATA_O <= rx_buf_q;
    end else if (hit(ADDR_I, `SPI_OFF_STAT)) begin
      RDATA_O <= 8'h00;
      RDATA_O[`SPI_STAT_DONE]  <= done_q;
      RDATA_O[`SPI_STAT_WRITE_COLLISION_FLAG]  <= write_collision_flag_q;
      RDATA_O[`SPI_STAT_FAULT] <= fault_q;
    end else if (hit(ADDR_I, `SPI_OFF_CTRL)) begin
      RDATA_O <= {irq_en_q, out_en_q, 1'b0, master_select_q, cpol_q, cpha_q, rate_q};
    end else begin
      RDATA_O <= `SPI_RDATA_RST;
    end
  end

  assign PAD_O      = pad_q;
  assign PAD_OE_N_O = pad_oe_n_q;

endmodule // spi_status_data_rate

//--- bench/spi_sdr_chk.sv
// pin-level assertions for the serial port block
module spi_sdr_chk
  import spi_sdr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              MCLK_I,
  input wire logic              RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0]        WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic              SS_N_I,
  input wire logic [7:0]        RDATA_O,
  input wire logic              IRQ_O,
  input wire pad_s              PAD_O,
  input wire pad_s              PAD_OE_N_O
);
  logic en_q;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // mirror of the interrupt enable bit; a fault never touches it
  always_ff @(posedge MCLK_I) begin
    if (RST_I) en_q <= 1'b0;
    else if (WR_I && ADDR_I == 8'h42) en_q <= WDATA_I[7];
  end
  sequence s_st;
    RD_I && ADDR_I == 8'h43;
  endsequence
  sequence s_dclr;
    s_st ##1 (RD_I && ADDR_I == 8'h40 && RDATA_O[7]);
  endsequence
  sequence s_fclr;
    s_st ##1 (WR_I && ADDR_I == 8'h42 && RDATA_O[4] && SS_N_I);
  endsequence
  a_irq_needs_en: assert property (IRQ_O |-> $past(en_q))
    else $error("irq without enable");
  a_irq_on_flag: assert property (s_st ##1 (RDATA_O[7] && $past(en_q)) |-> IRQ_O)
    else $error("irq missing");
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside slot");
  a_fault_drops_oe: assert property (!SS_N_I && !PAD_OE_N_O.sck |-> ##[1:3] PAD_OE_N_O.sck)
    else $error("outputs kept after fault");
  a_miso_needs_sel: assert property (!PAD_OE_N_O.miso |-> !$past(SS_N_I))
    else $error("miso driven unselected");
  a_slave_no_clk: assert property (!PAD_OE_N_O.miso |-> PAD_OE_N_O.sck && PAD_OE_N_O.mosi)
    else $error("slave drives clock");
  a_done_clr: assert property (s_dclr ##1 s_st |=> RDATA_O[7:6] == 2'b00)
    else $error("done not cleared");
  a_fault_clr: assert property (s_fclr ##1 s_st |=> !RDATA_O[4])
    else $error("fault not cleared");
endmodule // spi_sdr_chk

bind spi_status_data_rate spi_sdr_chk #(.ADDR_W(ADDR_W)) u_spi_sdr_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .SS_N_I(SS_N_I), .RDATA_O(RDATA_O),
  .IRQ_O(IRQ_O), .PAD_O(PAD_O), .PAD_OE_N_O(PAD_OE_N_O)
);

//--- bench/spi_slave_model.sv
// far-side serial slave, clock mode 0
module spi_slave_model (
  input  wire logic       sel_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_q;
  logic       last_q = 1'b0;
  always @(negedge sel_n_i) sh_q <= tx_i;
  always @(posedge sel_n_i) last_q <= sh_q[7];
  always @(posedge sck_i) if (!sel_n_i) rx_o <= {rx_o[6:0], mosi_i};
  always @(negedge sck_i) if (!sel_n_i) sh_q <= {sh_q[6:0], 1'b0};
  // released line shows the inverse so a stale bit never passes
  always_comb miso_o = sel_n_i ? ~last_q : sh_q[7];
endmodule // spi_slave_model

//--- bench/spi_status_data_rate_tb.sv
// self-checking bench for the serial port block
module spi_status_data_rate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_sdr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ss_n = 1'b1, sl_n = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, sl_tx = 8'h00, q = 8'h00, rdata, sl_rx;
  logic irq, miso_m;
  pad_s po, poe, pi;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #20 clk = ~clk;
  // released lines rest low; the model fills miso
  assign pi = {poe.sck ? 1'b0 : po.sck, poe.mosi ? 1'b0 : po.mosi, poe.miso ? miso_m : po.miso};
  spi_status_data_rate #(.DIV2_OPT(1'b0), .ADDR_W(8)) u_spi_status_data_rate (
    .MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
    .SS_N_I(ss_n), .PAD_I(pi), .RDATA_O(rdata), .IRQ_O(irq), .PAD_O(po), .PAD_OE_N_O(poe));
  spi_slave_model u_spi_slave_model (
    .sel_n_i(sl_n), .sck_i(pi.sck), .mosi_i(pi.mosi), .tx_i(sl_tx), .miso_o(miso_m), .rx_o(sl_rx));
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wd <= d;
  endtask
  task automatic stop();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  task automatic rdr(input logic [7:0] a);
    op(1'b0, a, 8'h00);
    stop();
  endtask
  task automatic wrr(input logic [7:0] a, d);
    op(1'b1, a, d);
    stop();
  endtask
  task automatic wait_done();
    q = 8'h00;
    for (int i = 0; i < 300 && q[7] !== 1'b1; i++) rdr(8'h43);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_reset();
    rdr(8'h43);
    chk("status", 8'h00, q & 8'hd0);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic t_rates();
    logic [7:0] hp[4] = '{8'h01, 8'h02, 8'h08, 8'h10};
    int n;
    for (int r = 0; r < 4; r++) begin
      n = 0;
      sl_tx = 8'h96 ^ r[7:0];
      sl_n <= 1'b0;
      wrr(8'h42, 8'h50 | r[7:0]);
      wrr(8'h40, 8'hc3 ^ r[7:0]);
      for (int i = 0; i < 80 && po.sck !== 1'b1; i++) @(negedge clk);
      while (po.sck === 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk("half period", hp[r], n[7:0]);
      wait_done();
      sl_n <= 1'b1;
      chk("mosi byte", 8'hc3 ^ r[7:0], sl_rx);
      rdr(8'h40);
      chk("rx buffer", sl_tx, q);
      rdr(8'h43);
      chk("done clear", 8'h00, q & 8'hd0);
    end
  endtask
  task automatic t_collide();
    sl_n <= 1'b0;
    wrr(8'h42, 8'h51);
    wrr(8'h40, 8'h3c);
    wrr(8'h40, 8'hff);
    wait_done();
    sl_n <= 1'b1;
    chk("collision", 8'hc0, q & 8'hd0);
    chk("mosi kept", 8'h3c, sl_rx);
    chk("no irq", 8'h00, {7'h00, irq});
    op(1'b0, 8'h43, 8'h00);
    op(1'b0, 8'h40, 8'h00);
    op(1'b0, 8'h43, 8'h00);
    stop();
    chk("both clear", 8'h00, q & 8'hd0);
  endtask
  task automatic t_irq();
    sl_n <= 1'b0;
    wrr(8'h42, 8'hd1);
    wrr(8'h40, 8'h81);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
    chk("irq on done", 8'h01, {7'h00, irq});
    wrr(8'h40, 8'h7e);
    repeat (60) @(negedge clk);
    sl_n <= 1'b1;
    chk("write ignored", 8'h81, sl_rx);
    wrr(8'h42, 8'h51);
    repeat (2) @(negedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    rdr(8'h43);
    rdr(8'h40);
  endtask
  task automatic t_fault();
    wrr(8'h42, 8'h50);
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    ss_n <= 1'b1;
    @(negedge clk);
    chk("oe released", 8'h01, {7'h00, poe.sck});
    wrr(8'h42, 8'h50);
    rdr(8'h42);
    chk("ctrl forced", 8'h00, q & 8'h50);
    rdr(8'h43);
    chk("fault", 8'h10, q & 8'hd0);
    op(1'b0, 8'h43, 8'h00);
    op(1'b1, 8'h42, 8'h50);
    op(1'b0, 8'h43, 8'h00);
    stop();
    chk("fault clear", 8'h00, q & 8'hd0);
    rdr(8'h42);
    chk("ctrl restored", 8'h50, q & 8'h50);
  endtask
  task automatic t_slave();
    wrr(8'h42, 8'h40);
    wrr(8'h40, 8'ha5);
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (40) @(negedge clk);
    chk("no clock", 8'h01, {7'h00, poe.sck});
    chk("miso on", 8'h00, {7'h00, poe.miso});
    chk("miso msb", 8'h01, {7'h00, po.miso});
    rdr(8'h43);
    chk("slave flags", 8'h00, q & 8'hd0);
    @(posedge clk);
    ss_n <= 1'b1;
  endtask
  task automatic t_keep();
    wrr(8'h42, 8'h03);
    do_reset();
    rdr(8'h42);
    chk("ctrl reset", 8'h03, q & 8'hd3);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_rates();
    t_collide();
    t_irq();
    t_fault();
    t_slave();
    t_keep();
    tally_and_finish();
  end
endmodule // spi_status_data_rate_tb
